// File: core/scp_pkg.sv
// Constants, types and register map of the SDRAM setup and power-saving block.
// Assumes a single 125 MHz clock; the SDRAM clock is taken to run at that rate.
//
// What this block does
// - Writing 1 to the power-saving bit enters power saving; 0 reads normal.
// - Leave power saving on external interrupt, key-scan wake-up or software wake-up.
// - Writing 0 wakes by software; bit reads 1 until the chip has resumed.
// - Mode 01b standby stops core and pixel clocks; memory clock from PLL.
// - Mode 10b suspend stops core and pixel clocks; memory clock from crystal.
// - Mode 11b sleep, the reset default, stops all clocks and PLLs; 00b undefined.
// - SDRAM enters power saving by power-down if select is 0, self-refresh if 1.
// - CAS field 010b selects 2 clocks, 011b (reset) 3 clocks; others reserved.
// - CAS-latency register ignores writes once init-done bit is set.
// - Refresh interval is 16 bits: low register [7:0], high register [15:8].
// - A refresh interval of 0000h issues no automatic refresh at all.
// - A 0-to-1 write of init-done starts init; reads 1 when ready; never back to 0.
package scp_pkg;

	// Clock and timing
	localparam int unsigned CLK_PERIOD_NS = 8;
	localparam int unsigned INIT_TIME_NS = 200000;
	localparam int unsigned INIT_CYCLES = (INIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned EXIT_TIME_NS = 70;
	localparam int unsigned EXIT_CYCLES = (EXIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Bus geometry
	localparam int unsigned ADDR_W = 10;
	localparam int unsigned DATA_W = 32;

	// Register indices; byte address is four times the index
	localparam logic [7:0] IDX_POWER = 8'hDF;
	localparam logic [7:0] IDX_GEOM = 8'hE0;
	localparam logic [7:0] IDX_MODE = 8'hE1;
	localparam logic [7:0] IDX_REF_LO = 8'hE2;
	localparam logic [7:0] IDX_REF_HI = 8'hE3;
	localparam logic [7:0] IDX_CTRL = 8'hE4;
	localparam logic [7:0] IDX_STATUS = 8'hF0;

	// Field positions
	localparam int unsigned PSC_ENTER_BIT = 7;
	localparam int unsigned GEOM_PSEL_BIT = 7;
	localparam int unsigned GEOM_BANK_BIT = 5;
	localparam int unsigned GEOM_ROW_LSB = 3;
	localparam int unsigned GEOM_COL_LSB = 0;
	localparam int unsigned CTRL_INIT_BIT = 0;
	localparam int unsigned STATUS_INIT_BIT = 0;
	localparam int unsigned STATUS_SAVE_BIT = 1;

	// Reset values
	localparam logic [1:0] PSC_MODE_RST = 2'h3;
	localparam logic [7:0] GEOM_RST = 8'h28;
	localparam logic [2:0] CAS_RST = 3'h3;
	localparam logic [15:0] REF_RST = 16'h0000;

	// CAS codes and their latencies
	localparam logic [2:0] CAS_CODE_2 = 3'h2;
	localparam logic [1:0] CAS_CLOCKS_2 = 2'h2;
	localparam logic [1:0] CAS_CLOCKS_3 = 2'h3;

	typedef enum logic [1:0] {
		PSM_NA = 2'b00,
		PSM_STANDBY = 2'b01,
		PSM_SUSPEND = 2'b10,
		PSM_SLEEP = 2'b11
	} scp_psave_mode_e;

	// Clock-gating controls handed to the clock generator
	typedef struct packed {
		logic core_en;
		logic pixel_en;
		logic mem_en;
		logic mem_from_crystal;
		logic pll_en;
	} scp_clk_s;

	// One-cycle command pulses to the SDRAM command sequencer
	typedef struct packed {
		logic init_start;
		logic power_down;
		logic self_refresh;
		logic exit_save;
		logic auto_refresh;
	} scp_dram_cmd_s;

endpackage

// File: core/scp_refresh_timer.sv
// Auto-refresh interval counter.
// Assumes one SDRAM clock per cycle of the block clock.
`timescale 1ns/1ps
module scp_refresh_timer import scp_pkg::*; #(
	parameter int unsigned WIDTH = 16
) (
	input wire logic ref_clk_in, // Block clock
	input wire logic reset_in, // Asynchronous reset, active high
	input wire logic enable_in, // Memory up and awake
	input wire logic [WIDTH-1:0] interval_in, // Programmed interval in clocks
	output logic refresh_out // One-cycle refresh request
);

	logic [WIDTH-1:0] count;
	logic [WIDTH-1:0] next_count;
	logic hit;

	// Zero interval never matches, so refresh stays off
	assign next_count = count + {{(WIDTH-1){1'b0}}, 1'b1};
	assign hit = (interval_in != '0) && (next_count >= interval_in);

	// Counter restarts after every request; also when interval shrinks below it
	always_ff @(posedge ref_clk_in or posedge reset_in) begin
		if (reset_in) begin
			count <= '0;
		end else if (!enable_in || hit) begin
			count <= '0;
		end else begin
			count <= next_count;
		end
	end

	// Request pulse is registered
	always_ff @(posedge ref_clk_in or posedge reset_in) begin
		if (reset_in) begin
			refresh_out <= 1'b0;
		end else begin
			refresh_out <= enable_in && hit;
		end
	end

endmodule

// File: core/scp_power_seq.sv
// Power-saving sequencer: entry, wake-up and clock gating.
// Assumes wake inputs are synchronous levels or pulses on the block clock.
`timescale 1ns/1ps
module scp_power_seq import scp_pkg::*; #(
	parameter int unsigned EXIT_WAIT = EXIT_CYCLES
) (
	input wire logic ref_clk_in, // Block clock
	input wire logic reset_in, // Asynchronous reset, active high
	input wire logic enter_req_in, // Software wrote 1
	input wire logic sw_wake_in, // Software wrote 0
	input wire logic ext_int_wake_in, // External interrupt wake
	input wire logic key_scan_wake_in, // Key-scan wake
	input wire logic [1:0] mode_in, // Power-saving mode field
	input wire logic self_refresh_sel_in, // 1 selects self-refresh
	output logic saving_out, // Power-saving bit readback
	output logic asleep_out, // SDRAM not available
	output scp_clk_s clk_ctrl_out, // Clock gating
	output logic power_down_out, // Power-down command pulse
	output logic self_refresh_out, // Self-refresh command pulse
	output logic exit_save_out // Exit command pulse
);

	typedef enum logic [1:0] {
		PS_RUN = 2'b00,
		PS_ENTER = 2'b01,
		PS_SAVE = 2'b10,
		PS_EXIT = 2'b11
	} scp_ps_state_e;

	localparam int unsigned EW = (EXIT_WAIT > 1) ? $clog2(EXIT_WAIT) : 1;
	localparam logic [EW-1:0] EXIT_LAST = EW'(EXIT_WAIT - 1);

	scp_ps_state_e state;
	logic [EW-1:0] wait_cnt;
	logic wake_any;
	logic wake_pend;
	scp_psave_mode_e mode_q;

	assign wake_any = ext_int_wake_in || key_scan_wake_in || sw_wake_in;

	// Mode is caught at entry so a later write cannot alter a sleep in progress
	always_ff @(posedge ref_clk_in or posedge reset_in) begin
		if (reset_in) begin
			mode_q <= PSM_SLEEP;
		end else if (state == PS_RUN && enter_req_in) begin
			mode_q <= scp_psave_mode_e'(mode_in);
		end
	end

	// Wake seen while still entering is kept, not dropped
	always_ff @(posedge ref_clk_in or posedge reset_in) begin
		if (reset_in) begin
			wake_pend <= 1'b0;
		end else if (state == PS_ENTER || state == PS_SAVE) begin
			wake_pend <= wake_pend || wake_any;
		end else begin
			wake_pend <= 1'b0;
		end
	end

	// Main sequence; SDRAM is woken before the bit drops back to 0
	always_ff @(posedge ref_clk_in or posedge reset_in) begin
		if (reset_in) begin
			state <= PS_RUN;
			wait_cnt <= '0;
		end else begin
			case (state)
				PS_RUN: begin
					if (enter_req_in) begin
						state <= PS_ENTER;
					end
				end
				PS_ENTER: begin
					state <= PS_SAVE;
				end
				PS_SAVE: begin
					if (wake_pend || wake_any) begin
						state <= PS_EXIT;
						wait_cnt <= '0;
					end
				end
				PS_EXIT: begin
					if (wait_cnt == EXIT_LAST) begin
						state <= enter_req_in ? PS_ENTER : PS_RUN;
					end else begin
						wait_cnt <= wait_cnt + {{(EW-1){1'b0}}, 1'b1};
					end
				end
				default: state <= PS_RUN;
			endcase
		end
	end

	// Bit stays 1 through the exit wait
	assign saving_out = (state != PS_RUN);
	assign asleep_out = (state != PS_RUN);

	// Commands and gating are registered
	always_ff @(posedge ref_clk_in or posedge reset_in) begin
		if (reset_in) begin
			power_down_out <= 1'b0;
			self_refresh_out <= 1'b0;
			exit_save_out <= 1'b0;
			clk_ctrl_out <= '{core_en: 1'b1, pixel_en: 1'b1, mem_en: 1'b1,
				mem_from_crystal: 1'b0, pll_en: 1'b1};
		end else begin
			power_down_out <= (state == PS_ENTER) && !self_refresh_sel_in;
			self_refresh_out <= (state == PS_ENTER) && self_refresh_sel_in;
			exit_save_out <= (state == PS_SAVE) && (wake_pend || wake_any);
			if (state == PS_SAVE) begin
				clk_ctrl_out.core_en <= 1'b0;
				clk_ctrl_out.pixel_en <= 1'b0;
				case (mode_q)
					PSM_STANDBY: begin
						clk_ctrl_out.mem_en <= 1'b1;
						clk_ctrl_out.mem_from_crystal <= 1'b0;
						clk_ctrl_out.pll_en <= 1'b1;
					end
					PSM_SUSPEND: begin
						clk_ctrl_out.mem_en <= 1'b1;
						clk_ctrl_out.mem_from_crystal <= 1'b1;
						clk_ctrl_out.pll_en <= 1'b0;
					end
					default: begin
						clk_ctrl_out.mem_en <= 1'b0;
						clk_ctrl_out.mem_from_crystal <= 1'b0;
						clk_ctrl_out.pll_en <= 1'b0;
					end
				endcase
			end else begin
				clk_ctrl_out <= '{core_en: 1'b1, pixel_en: 1'b1, mem_en: 1'b1,
					mem_from_crystal: 1'b0, pll_en: 1'b1};
			end
		end
	end

endmodule

// File: core/scp_dram_pm_top.sv
// Top of the SDRAM setup and power-saving block: Avalon-MM register slave,
// initialization timer, refresh timer and power-saving sequencer.
// Assumes an Avalon-MM master that holds each request until waitrequest is low.
//
// Decided for this implementation: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module scp_dram_pm_top import scp_pkg::*; #(
	parameter int unsigned INIT_WAIT = INIT_CYCLES,
	parameter int unsigned EXIT_WAIT = EXIT_CYCLES,
	parameter int unsigned REF_W = 16
) (
	input wire logic ref_clk_in, // Block clock, 125 MHz
	input wire logic reset_in, // Asynchronous reset, active high
	input wire logic [ADDR_W-1:0] avs_address_in, // Byte address
	input wire logic avs_read_in, // Read request
	input wire logic avs_write_in, // Write request
	input wire logic [DATA_W-1:0] avs_writedata_in, // Write data
	input wire logic [3:0] avs_byteenable_in, // Byte lanes
	output logic [DATA_W-1:0] avs_readdata_out, // Read data
	output logic avs_waitrequest_out, // Hold request
	input wire logic ext_int_wake_in, // External interrupt wake
	input wire logic key_scan_wake_in, // Key-scan wake
	output scp_clk_s clk_ctrl_out, // Clock gating
	output scp_dram_cmd_s dram_cmd_out, // SDRAM command pulses
	output logic dram_bank_count_out, // Bank-count field
	output logic [1:0] dram_row_count_out, // Row field
	output logic [2:0] dram_column_count_out, // Column field
	output logic [2:0] cas_latency_select_out, // CAS code
	output logic [1:0] cas_clocks_out, // CAS latency in clocks
	output logic dram_init_complete_out // Memory initialized
);

	localparam int unsigned IW = (INIT_WAIT > 1) ? $clog2(INIT_WAIT) : 1;
	localparam logic [IW-1:0] INIT_LAST = IW'(INIT_WAIT - 1);

	// Bus handshake state
	logic ack;
	logic req;
	logic wr_now;
	logic [7:0] idx;
	logic aligned;
	logic lane0;
	logic [7:0] wbyte;

	// Register contents
	logic psave_enter;
	logic [1:0] psave_mode;
	logic [7:0] geom;
	logic [2:0] cas_sel;
	logic [REF_W-1:0] ref_interval;
	logic init_busy;
	logic init_done;
	logic [IW-1:0] init_cnt;

	// Sequencer links
	logic enter_req;
	logic sw_wake;
	logic saving;
	logic asleep;
	logic pd_cmd;
	logic sr_cmd;
	logic exit_cmd;
	logic refresh_cmd;
	logic init_start;
	logic [7:0] next_rdata;

	// Request decode; only word-aligned accesses reach a register, and writes also need lane 0
	assign req = avs_read_in || avs_write_in;
	assign idx = avs_address_in[ADDR_W-1:2];
	assign aligned = (avs_address_in[1:0] == 2'h0);
	assign lane0 = avs_byteenable_in[0];
	assign wbyte = avs_writedata_in[7:0];
	assign wr_now = avs_write_in && ack && aligned && lane0;

	// One wait state on every access, so read data can be registered
	assign avs_waitrequest_out = req && !ack;

	always_ff @(posedge ref_clk_in or posedge reset_in) begin
		if (reset_in) begin
			ack <= 1'b0;
		end else begin
			ack <= req && !ack;
		end
	end

	// Power-saving register; writes during saving other than bit 7 are not blocked,
	// the host is trusted to wait for the bit to drop
	always_ff @(posedge ref_clk_in or posedge reset_in) begin
		if (reset_in) begin
			psave_mode <= PSC_MODE_RST;
		end else if (wr_now && idx == IDX_POWER) begin
			psave_mode <= wbyte[1:0];
		end
	end

	// Writing 1 requests entry; writing 0 while saving requests a software wake
	assign enter_req = wr_now && (idx == IDX_POWER) && wbyte[PSC_ENTER_BIT] && !saving;
	assign sw_wake = wr_now && (idx == IDX_POWER) && !wbyte[PSC_ENTER_BIT] && saving;

	// Latched entry request covers the cycle before the sequencer leaves idle
	always_ff @(posedge ref_clk_in or posedge reset_in) begin
		if (reset_in) begin
			psave_enter <= 1'b0;
		end else begin
			psave_enter <= enter_req;
		end
	end

	// Geometry register; the host must program it to match the memory
	always_ff @(posedge ref_clk_in or posedge reset_in) begin
		if (reset_in) begin
			geom <= GEOM_RST;
		end else if (wr_now && idx == IDX_GEOM) begin
			geom <= wbyte;
		end
	end

	// CAS-latency register locks once initialization has been requested
	always_ff @(posedge ref_clk_in or posedge reset_in) begin
		if (reset_in) begin
			cas_sel <= CAS_RST;
		end else if (wr_now && idx == IDX_MODE && !init_busy && !init_done) begin
			cas_sel <= wbyte[2:0];
		end
	end

	// Refresh interval, split across two byte registers
	always_ff @(posedge ref_clk_in or posedge reset_in) begin
		if (reset_in) begin
			ref_interval <= REF_RST;
		end else if (wr_now && idx == IDX_REF_LO) begin
			ref_interval[7:0] <= wbyte;
		end else if (wr_now && idx == IDX_REF_HI) begin
			ref_interval[15:8] <= wbyte;
		end
	end

	// Initialization: a 0-to-1 write starts the timer, done is sticky
	assign init_start = wr_now && (idx == IDX_CTRL) && wbyte[CTRL_INIT_BIT]
		&& !init_busy && !init_done;

	always_ff @(posedge ref_clk_in or posedge reset_in) begin
		if (reset_in) begin
			init_busy <= 1'b0;
			init_done <= 1'b0;
			init_cnt <= '0;
		end else if (init_start) begin
			init_busy <= 1'b1;
			init_cnt <= '0;
		end else if (init_busy) begin
			if (init_cnt == INIT_LAST) begin
				init_busy <= 1'b0;
				init_done <= 1'b1;
			end else begin
				init_cnt <= init_cnt + {{(IW-1){1'b0}}, 1'b1};
			end
		end
	end

	// Read multiplexer; unmapped or misaligned addresses read zero
	always_comb begin
		next_rdata = 8'h00;
		if (!aligned) begin
			next_rdata = 8'h00;
		end else if (idx == IDX_POWER) begin
			next_rdata = {saving, 5'h00, psave_mode};
		end else if (idx == IDX_GEOM) begin
			next_rdata = geom;
		end else if (idx == IDX_MODE) begin
			next_rdata = {5'h00, cas_sel};
		end else if (idx == IDX_REF_LO) begin
			next_rdata = ref_interval[7:0];
		end else if (idx == IDX_REF_HI) begin
			next_rdata = ref_interval[15:8];
		end else if (idx == IDX_CTRL) begin
			next_rdata = {7'h00, init_done};
		end else if (idx == IDX_STATUS) begin
			next_rdata = {6'h00, saving, init_done};
		end
	end

	// Read data registered on the first cycle of the request
	always_ff @(posedge ref_clk_in or posedge reset_in) begin
		if (reset_in) begin
			avs_readdata_out <= '0;
		end else if (avs_read_in && !ack) begin
			avs_readdata_out <= {24'h000000, next_rdata};
		end
	end

	// Decoded geometry and latency, registered for the command sequencer
	always_ff @(posedge ref_clk_in or posedge reset_in) begin
		if (reset_in) begin
			dram_bank_count_out <= GEOM_RST[GEOM_BANK_BIT];
			dram_row_count_out <= GEOM_RST[GEOM_ROW_LSB +: 2];
			dram_column_count_out <= GEOM_RST[GEOM_COL_LSB +: 3];
			cas_latency_select_out <= CAS_RST;
			cas_clocks_out <= CAS_CLOCKS_3;
		end else begin
			dram_bank_count_out <= geom[GEOM_BANK_BIT];
			dram_row_count_out <= geom[GEOM_ROW_LSB +: 2];
			dram_column_count_out <= geom[GEOM_COL_LSB +: 3];
			cas_latency_select_out <= cas_sel;
			// Reserved codes fall back to the longer, safer latency
			cas_clocks_out <= (cas_sel == CAS_CODE_2) ? CAS_CLOCKS_2 : CAS_CLOCKS_3;
		end
	end

	assign dram_init_complete_out = init_done;

	// Power-saving sequencer
	scp_power_seq #(
		.EXIT_WAIT(EXIT_WAIT)
	) u_power_seq (
		.ref_clk_in(ref_clk_in),
		.reset_in(reset_in),
		.enter_req_in(psave_enter),
		.sw_wake_in(sw_wake),
		.ext_int_wake_in(ext_int_wake_in),
		.key_scan_wake_in(key_scan_wake_in),
		.mode_in(psave_mode),
		.self_refresh_sel_in(geom[GEOM_PSEL_BIT]),
		.saving_out(saving),
		.asleep_out(asleep),
		.clk_ctrl_out(clk_ctrl_out),
		.power_down_out(pd_cmd),
		.self_refresh_out(sr_cmd),
		.exit_save_out(exit_cmd)
	);

	// Refresh only runs on initialized, awake memory
	scp_refresh_timer #(
		.WIDTH(REF_W)
	) u_refresh_timer (
		.ref_clk_in(ref_clk_in),
		.reset_in(reset_in),
		.enable_in(init_done && !asleep),
		.interval_in(ref_interval),
		.refresh_out(refresh_cmd)
	);

	// Command pulses gathered for the sequencer
	always_ff @(posedge ref_clk_in or posedge reset_in) begin
		if (reset_in) begin
			dram_cmd_out <= '0;
		end else begin
			dram_cmd_out.init_start <= init_start;
			dram_cmd_out.power_down <= pd_cmd;
			dram_cmd_out.self_refresh <= sr_cmd;
			dram_cmd_out.exit_save <= exit_cmd;
			dram_cmd_out.auto_refresh <= refresh_cmd;
		end
	end

endmodule

// File: test/scp_dram_pm_checker.sv
// Concurrent checks on the ports of the SDRAM setup and power-saving top.
// Assumes one clock domain and a master that holds each request until accepted.
`timescale 1ns/1ps
module scp_dram_pm_checker import scp_pkg::*; (
	input wire logic ref_clk_in, // Block clock
	input wire logic reset_in, // Reset, active high
	input wire logic [ADDR_W-1:0] avs_address_in, // Byte address
	input wire logic avs_write_in, // Write request
	input wire logic [DATA_W-1:0] avs_writedata_in, // Write data
	input wire logic [3:0] avs_byteenable_in, // Byte lanes
	input wire logic avs_waitrequest_out, // Hold request
	input wire logic ext_int_wake_in, // Interrupt wake
	input wire logic key_scan_wake_in, // Key-scan wake
	input wire scp_clk_s clk_ctrl_out, // Clock gating
	input wire scp_dram_cmd_s dram_cmd_out, // Command pulses
	input wire logic [2:0] cas_latency_select_out, // CAS code
	input wire logic [1:0] cas_clocks_out, // CAS clocks
	input wire logic dram_init_complete_out // Init done
);
	logic wr_acc;
	logic [1:0] mode_q;
	logic sel_q;
	logic seen_init;

	// Write accepted on lane 0 at an aligned address
	assign wr_acc = avs_write_in && !avs_waitrequest_out && avs_byteenable_in[0]
		&& avs_address_in[1:0] == 2'h0;

	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (reset_in);

	// Shadows of mode and select, so gating can be judged without peeking inside
	always_ff @(posedge ref_clk_in or posedge reset_in) begin
		if (reset_in) begin
			mode_q <= PSC_MODE_RST;
			sel_q <= GEOM_RST[GEOM_PSEL_BIT];
			seen_init <= 1'b0;
		end else begin
			if (wr_acc && avs_address_in[9:2] == IDX_POWER)
				mode_q <= avs_writedata_in[1:0];
			if (wr_acc && avs_address_in[9:2] == IDX_GEOM)
				sel_q <= avs_writedata_in[GEOM_PSEL_BIT];
			if (dram_cmd_out.init_start)
				seen_init <= 1'b1;
		end
	end

	sequence s_wr(logic [7:0] idx);
		wr_acc && avs_address_in[9:2] == idx;
	endsequence

	sequence s_gated;
		!clk_ctrl_out.core_en && !clk_ctrl_out.pixel_en;
	endsequence

	standby_gate_a:
		assert property (s_gated ##0 mode_q == 2'h1 |-> clk_ctrl_out.mem_en
			&& !clk_ctrl_out.mem_from_crystal && clk_ctrl_out.pll_en)
		else $error("standby clocks wrong");
	suspend_gate_a:
		assert property (s_gated ##0 mode_q == 2'h2 |-> clk_ctrl_out.mem_en
			&& clk_ctrl_out.mem_from_crystal)
		else $error("suspend clocks wrong");
	sleep_gate_a:
		assert property (s_gated ##0 mode_q == 2'h3 |-> !clk_ctrl_out.mem_en
			&& !clk_ctrl_out.pll_en)
		else $error("sleep clocks wrong");
	cmd_select_a:
		assert property (dram_cmd_out.power_down || dram_cmd_out.self_refresh
			|-> dram_cmd_out.self_refresh == sel_q && dram_cmd_out.power_down != sel_q)
		else $error("wrong entry command");
	cas_map_a:
		assert property ($stable(cas_latency_select_out) |-> cas_clocks_out ==
			((cas_latency_select_out == CAS_CODE_2) ? CAS_CLOCKS_2 : CAS_CLOCKS_3))
		else $error("cas clocks wrong");
	cas_lock_a:
		assert property (dram_init_complete_out |=> $stable(cas_latency_select_out))
		else $error("cas changed after init");
	init_sticky_a:
		assert property (dram_init_complete_out |=> dram_init_complete_out)
		else $error("init done dropped");
	init_start_a:
		assert property (s_wr(IDX_CTRL) ##0 avs_writedata_in[CTRL_INIT_BIT] && !seen_init
			|-> ##[1:2] dram_cmd_out.init_start)
		else $error("no init start");
	refresh_gate_a:
		assert property (dram_cmd_out.auto_refresh |-> dram_init_complete_out
			&& clk_ctrl_out.core_en)
		else $error("refresh while unavailable");
	hw_wake_a:
		assert property ($rose(ext_int_wake_in || key_scan_wake_in) && !clk_ctrl_out.core_en
			|-> ##[1:4] dram_cmd_out.exit_save)
		else $error("no exit on wake");
	sw_wake_a:
		assert property (s_wr(IDX_POWER) ##0 !avs_writedata_in[PSC_ENTER_BIT]
			&& !clk_ctrl_out.core_en |-> ##[1:6] dram_cmd_out.exit_save)
		else $error("no exit on software wake");
endmodule

bind scp_dram_pm_top scp_dram_pm_checker scp_dram_pm_checker_i (.ref_clk_in, .reset_in,
	.avs_address_in, .avs_write_in, .avs_writedata_in, .avs_byteenable_in,
	.avs_waitrequest_out, .ext_int_wake_in, .key_scan_wake_in, .clk_ctrl_out,
	.dram_cmd_out, .cas_latency_select_out, .cas_clocks_out, .dram_init_complete_out);

// File: test/scp_sdram_model.sv
// Behavioural model of the embedded SDRAM die, seen through its command pulses.
// Assumes one-cycle pulses on the block clock; counts every illegal command.
`timescale 1ns/1ps
module scp_sdram_model import scp_pkg::*; (
	input wire logic ref_clk_in, // Block clock
	input wire logic reset_in, // Reset, active high
	input wire scp_dram_cmd_s cmd_in, // Command pulses
	output logic ready_out, // Initialized
	output logic pd_out, // In power-down
	output logic sr_out, // In self-refresh
	output logic [7:0] fault_out // Illegal commands seen
);
	logic bad_cmd;

	// Strict: refresh or entry before init, or while asleep, is a fault
	assign bad_cmd = (cmd_in.auto_refresh && (!ready_out || pd_out || sr_out))
		|| ((cmd_in.power_down || cmd_in.self_refresh) && (!ready_out || pd_out || sr_out))
		|| (cmd_in.exit_save && !(pd_out || sr_out));

	// Memory state follows the commands
	always_ff @(posedge ref_clk_in or posedge reset_in) begin
		if (reset_in) begin
			ready_out <= 1'b0;
			pd_out <= 1'b0;
			sr_out <= 1'b0;
			fault_out <= 8'h00;
		end else begin
			if (cmd_in.init_start)
				ready_out <= 1'b1;
			if (cmd_in.power_down)
				pd_out <= 1'b1;
			if (cmd_in.self_refresh)
				sr_out <= 1'b1;
			if (cmd_in.exit_save) begin
				pd_out <= 1'b0;
				sr_out <= 1'b0;
			end
			if (bad_cmd)
				fault_out <= fault_out + 8'h01;
		end
	end
endmodule

// File: test/scp_dram_pm_tb.sv
// Self-checking bench for the SDRAM setup and power-saving top.
// Assumes the top is built with a short init wait; drives Avalon-MM as a master.
`timescale 1ns/1ps
module scp_dram_pm_tb import scp_pkg::*;;
	logic ref_clk_in = 1'b0;
	logic reset_in = 1'b1;
	logic [ADDR_W-1:0] avs_address_in = '0;
	logic avs_read_in = 1'b0;
	logic avs_write_in = 1'b0;
	logic [DATA_W-1:0] avs_writedata_in = '0;
	logic [3:0] avs_byteenable_in = 4'hF;
	logic [DATA_W-1:0] avs_readdata_out;
	logic avs_waitrequest_out;
	logic ext_int_wake_in = 1'b0;
	logic key_scan_wake_in = 1'b0;
	scp_clk_s clk_ctrl_out;
	scp_dram_cmd_s dram_cmd_out;
	logic dram_bank_count_out;
	logic [1:0] dram_row_count_out;
	logic [2:0] dram_column_count_out;
	logic [2:0] cas_latency_select_out;
	logic [1:0] cas_clocks_out;
	logic dram_init_complete_out;
	logic ready, pd, sr;
	logic [7:0] faults;
	logic [31:0] rd;
	int bad_count = 0;
	int checked = 0;

	// Short init wait keeps the run brief
	scp_dram_pm_top #(.INIT_WAIT(20)) scp_dram_pm_top_i (.ref_clk_in, .reset_in,
		.avs_address_in, .avs_read_in, .avs_write_in, .avs_writedata_in, .avs_byteenable_in,
		.avs_readdata_out, .avs_waitrequest_out, .ext_int_wake_in, .key_scan_wake_in,
		.clk_ctrl_out, .dram_cmd_out, .dram_bank_count_out, .dram_row_count_out,
		.dram_column_count_out, .cas_latency_select_out, .cas_clocks_out,
		.dram_init_complete_out);
	scp_sdram_model scp_sdram_model_i (.ref_clk_in, .reset_in, .cmd_in(dram_cmd_out),
		.ready_out(ready), .pd_out(pd), .sr_out(sr), .fault_out(faults));

	// 125 MHz clock
	always #4 ref_clk_in = ~ref_clk_in;

	task report_and_stop;
		$display("Mismatches %0d, comparisons %0d", bad_count, checked);
		if (bad_count == 0 && checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("Error at %0t: saw %0h, expected %0h", $time, seen, exp);
		end
	endtask

	// One Avalon-MM transfer; held until waitrequest is sampled low
	task bus(input logic rd_op, input logic [7:0] idx, input logic [7:0] data);
		int n;
		@(posedge ref_clk_in);
		avs_address_in <= {idx, 2'b00};
		avs_read_in <= rd_op;
		avs_write_in <= !rd_op;
		avs_writedata_in <= {24'h0, data};
		n = 0;
		do begin
			@(posedge ref_clk_in);
			n++;
		end while (avs_waitrequest_out !== 1'b0 && n < 40);
		rd = avs_readdata_out;
		avs_read_in <= 1'b0;
		avs_write_in <= 1'b0;
		if (n >= 40) begin
			bad_count++;
			$display("Error at %0t: bus request never answered", $time);
			report_and_stop();
		end
	endtask

	task wr(input logic [7:0] idx, input logic [7:0] data);
		bus(1'b0, idx, data);
	endtask

	task rd_chk(input logic [7:0] idx, input logic [7:0] exp);
		bus(1'b1, idx, 8'h00);
		check(rd, {24'h0, exp});
	endtask

	// Cycles up to the next refresh pulse, capped at the limit
	task gap(input int limit, output int n);
		n = 0;
		do begin
			@(posedge ref_clk_in);
			n++;
		end while (dram_cmd_out.auto_refresh !== 1'b1 && n < limit);
	endtask

	task t_reset_map;
		rd_chk(IDX_POWER, {6'h00, PSC_MODE_RST});
		rd_chk(IDX_GEOM, GEOM_RST);
		rd_chk(IDX_MODE, {5'h00, CAS_RST});
		rd_chk(IDX_REF_LO, REF_RST[7:0]);
		rd_chk(IDX_REF_HI, REF_RST[15:8]);
		check(cas_clocks_out, CAS_CLOCKS_3);
		wr(8'hD8, 8'hFF);
		rd_chk(8'hD8, 8'h00);
	endtask

	task t_setup_init;
		int n;
		wr(IDX_GEOM, 8'h20);
		// Decoded fields are registered one edge after the register itself
		repeat (2) @(posedge ref_clk_in);
		check({dram_bank_count_out, dram_row_count_out, dram_column_count_out}, 6'h20);
		wr(IDX_MODE, 8'h02);
		repeat (2) @(posedge ref_clk_in);
		check({cas_latency_select_out, cas_clocks_out}, {CAS_CODE_2, CAS_CLOCKS_2});
		wr(IDX_MODE, 8'h05);
		repeat (2) @(posedge ref_clk_in);
		check(cas_clocks_out, CAS_CLOCKS_3);
		wr(IDX_MODE, 8'h03);
		wr(IDX_CTRL, 8'h01);
		n = 0;
		while (dram_init_complete_out !== 1'b1 && n < 100) begin
			@(posedge ref_clk_in);
			n++;
		end
		check({dram_init_complete_out, ready}, 2'b11);
		wr(IDX_MODE, 8'h02);
		rd_chk(IDX_MODE, 8'h03);
		wr(IDX_CTRL, 8'h00);
		rd_chk(IDX_CTRL, 8'h01);
	endtask

	task t_refresh;
		int n;
		wr(IDX_REF_LO, 8'h05);
		gap(50, n);
		gap(50, n);
		check(n, 5);
		wr(IDX_REF_LO, 8'h00);
		wr(IDX_REF_HI, 8'h01);
		gap(600, n);
		gap(600, n);
		check(n, 256);
		wr(IDX_REF_HI, 8'h00);
		gap(20, n);
		gap(300, n);
		check(n, 300);
		wr(IDX_REF_HI, 8'h06);
		wr(IDX_REF_LO, 8'h1A);
	endtask

	// Mode i+1, select i[0]; wake by interrupt, key scan, then software
	task t_power(input int i);
		logic [1:0] mode;
		int n;
		mode = 2'(i + 1);
		wr(IDX_GEOM, {i[0], 7'h20});
		wr(IDX_POWER, {6'h20, mode});
		n = 0;
		do begin
			bus(1'b1, IDX_POWER, 8'h00);
			n++;
		end while (rd[7] !== 1'b1 && n < 20);
		check(rd[7], 1'b1);
		rd_chk(IDX_STATUS, 8'h03);
		n = 0;
		while (clk_ctrl_out.core_en !== 1'b0 && n < 20) begin
			@(posedge ref_clk_in);
			n++;
		end
		repeat (2) @(posedge ref_clk_in);
		check({clk_ctrl_out.core_en, clk_ctrl_out.pixel_en, clk_ctrl_out.mem_en},
			{2'b00, mode != 2'h3});
		if (mode != 2'h3)
			check(clk_ctrl_out.mem_from_crystal, mode == 2'h2);
		if (mode != 2'h2)
			check(clk_ctrl_out.pll_en, mode == 2'h1);
		check({pd, sr}, {!i[0], i[0]});
		if (i == 2) begin
			wr(IDX_POWER, {6'h00, mode});
			rd_chk(IDX_POWER, {6'h20, mode});
		end else begin
			ext_int_wake_in <= (i == 0);
			key_scan_wake_in <= (i == 1);
			@(posedge ref_clk_in);
			ext_int_wake_in <= 1'b0;
			key_scan_wake_in <= 1'b0;
		end
		n = 0;
		do begin
			bus(1'b1, IDX_POWER, 8'h00);
			n++;
		end while (rd[7] !== 1'b0 && n < 40);
		check(rd[7], 1'b0);
		check({pd, sr}, 2'b00);
		check(clk_ctrl_out, 5'b11101);
	endtask

	// Main sequence
	initial begin
		repeat (4) @(posedge ref_clk_in);
		reset_in <= 1'b0;
		t_reset_map();
		t_setup_init();
		t_refresh();
		for (int i = 0; i < 3; i++)
			t_power(i);
		check(faults, 8'h00);
		report_and_stop();
	end
endmodule
